// *** lpmc_ctrl_end.sv ***
// control end: clock gating, regulator and supply sequencing for low-power modes
`timescale 1ns/1ns
// Operation
// - wait mode stops core, peripheral, memory clocks
// - wait mode keeps all supplies on
// - wait entered by wait-for-event with select 1
// - sixteen wake lines configurable as fast wakes
// - calendar, timer or usb events end wait
// - software selects fast rc, sets bit, waits
// - software polls oscillator enable cleared first
// - restart from wait under ten microseconds
// - sleep stops only the core clock
// - sleep entered by either instruction, select 0
// - sleep wakes by interrupt or event accordingly
// - backup wake re-enables core and sram supplies
// - backup wakes: debounced lines, monitor, alarms
// - backup forces regulator output to ground
// - allow regulator start-up before core release
// - software may disable regulator, not backup
// - supply controller on own slow clock, reset; here a divided system-clock tick and sys_rst
module lpmc_ctrl_end (
    input  wire logic        clock,             // system clock, 25 MHz
    input  wire logic        sys_rst,           // synchronous reset, high
    lpmc_if.ctrl             bus,               // link to core end
    input  wire logic [15:0] fastWakeLines,     // fast wake pins, asynchronous
    input  wire logic [15:0] fastWakeEnable,    // per-line fast wake enable
    input  wire logic [15:0] backupWakeInputs,  // backup wake pins, asynchronous
    input  wire logic [15:0] backupWakeEnable,  // per-line backup wake enable
    input  wire logic [3:0]  debounceTicks,     // slow ticks a line must hold
    input  wire logic        calendarAlarm,     // calendar alarm, asynchronous
    input  wire logic        realtimeTimerAlarm,// timer alarm, asynchronous
    input  wire logic        usbWake,           // usb wake-up, asynchronous
    input  wire logic        supplyMonAlarm,    // supply monitor alarm, asynchronous
    input  wire logic        irqPending,        // interrupt pending, asynchronous
    input  wire logic        eventPending,      // event pending, asynchronous
    output logic             periphClkEn,       // peripheral clock gate
    output logic             memClkEn,          // memory clock gate
    output logic             corePowerEn,       // core supply on
    output logic             sramPowerEn,       // sram supply on
    output logic             regulatorOn,       // regulator in normal mode
    output logic             regulatorOutputGnd // regulator output forced to ground
);
    import lpmc_pkg::*;

    localparam int SYNC_W = 38; // 16 fast lines, 16 backup lines, 6 single sources

    lpmc_mode_t       mode;
    logic             enteredByWfi;
    logic [15:0]      cnt;
    logic [SYNC_W-1:0] syncA;
    logic [SYNC_W-1:0] syncB;
    logic [15:0]      fwSync;
    logic [15:0]      bwSync;
    logic [15:0]      bwPrev;
    logic             calSync, rttSync, usbSync, smSync, irqSync, evtSync;
    logic [9:0]       slowDiv;
    logic             slowTick;
    logic [3:0]       deb [16];
    logic [15:0]      bwHit;
    logic             fastWake;
    logic             backupWake;
    logic             sleepWake;

    // ****************************************************************
    // two-stage synchronisers for every asynchronous input
    // ****************************************************************
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            syncA <= '0;
            syncB <= '0;
        end else begin
            syncA <= {fastWakeLines, backupWakeInputs, calendarAlarm, realtimeTimerAlarm, usbWake,
                      supplyMonAlarm, irqPending, eventPending};
            syncB <= syncA;
        end
    end
    assign fwSync  = syncB[37:22];
    assign bwSync  = syncB[21:6];
    assign calSync = syncB[5];
    assign rttSync = syncB[4];
    assign usbSync = syncB[3];
    assign smSync  = syncB[2];
    assign irqSync = syncB[1];
    assign evtSync = syncB[0];

    // ****************************************************************
    // slow-clock tick for supply controller; shares sys_rst
    // ****************************************************************
    // a divided tick stands in for the 32 kHz clock, keeping one clock domain
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            slowDiv  <= '0;
            slowTick <= 1'b0;
        end else begin
            slowTick <= (slowDiv == 10'(SLOW_DIV - 1));
            slowDiv  <= (slowDiv == 10'(SLOW_DIV - 1)) ? 10'h000 : slowDiv + 10'h001;
        end
    end

    // ****************************************************************
    // backup wake lines: transition then debounce on slow ticks
    // ****************************************************************
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            bwPrev <= '0;
            bwHit  <= '0;
            for (int i = 0; i < 16; i++) begin
                deb[i] <= DEBOUNCE_RST;
            end
        end else begin
            for (int i = 0; i < 16; i++) begin
                bwHit[i] <= 1'b0;
                if (bwSync[i] != bwPrev[i]) begin
                    deb[i] <= 4'h0; // level moved, restart count
                    bwPrev[i] <= bwSync[i];
                end else if (slowTick && deb[i] != 4'hf) begin
                    deb[i] <= deb[i] + 4'h1;
                    bwHit[i] <= (deb[i] == debounceTicks) & backupWakeEnable[i];
                end
            end
        end
    end

    assign fastWake   = |(fwSync & fastWakeEnable) | calSync | rttSync | usbSync;
    assign backupWake = (|bwHit) | smSync | calSync | rttSync;
    assign sleepWake  = enteredByWfi ? irqSync : evtSync;

    // ****************************************************************
    // mode sequencer
    // ****************************************************************
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            mode         <= PM_RUN;
            enteredByWfi <= 1'b0;
            cnt          <= '0;
        end else begin
            case (mode)
                PM_RUN: begin
                    cnt <= '0;
                    if (bus.backupReq) begin
                        mode <= PM_BACKUP;
                    end else if (bus.waitForEventInstr && bus.lowPowerSelect) begin
                        mode <= PM_WAIT; // select sampled with the instruction
                    end else if (bus.waitForEventInstr || bus.waitForInterruptInstr) begin
                        enteredByWfi <= bus.waitForInterruptInstr;
                        mode <= PM_SLEEP;
                    end
                end
                PM_WAIT: begin
                    if (fastWake) begin
                        mode <= PM_RESTORE;
                    end
                end
                PM_SLEEP: begin
                    if (sleepWake) begin
                        mode <= PM_RESTORE;
                    end
                end
                PM_BACKUP: begin
                    if (backupWake) begin
                        mode <= PM_REGUP;
                    end
                end
                PM_REGUP: begin
                    cnt <= cnt + 16'h0001;
                    if (cnt == 16'(REG_STARTUP_CYC - 1)) begin
                        cnt  <= '0;
                        mode <= PM_RESTORE; // regulator settled
                    end
                end
                PM_RESTORE: begin
                    cnt <= cnt + 16'h0001;
                    if (cnt == 16'(CLK_RESTORE_CYC - 1)) begin
                        mode <= PM_RUN; // clocks ran before core release
                    end
                end
                default: mode <= PM_RUN;
            endcase
        end
    end

    // ****************************************************************
    // gates, supplies and regulator from the mode
    // ****************************************************************
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            bus.coreClkEn      <= 1'b1;
            periphClkEn        <= 1'b1;
            memClkEn           <= 1'b1;
            corePowerEn        <= 1'b1;
            sramPowerEn        <= 1'b1;
            regulatorOn        <= 1'b1;
            regulatorOutputGnd <= 1'b0;
            bus.coreRun        <= 1'b1;
            bus.coreWake       <= 1'b0;
        end else begin
            bus.coreClkEn      <= (mode == PM_RUN) || (mode == PM_RESTORE);
            periphClkEn        <= (mode != PM_WAIT) && (mode != PM_BACKUP) && (mode != PM_REGUP);
            memClkEn           <= (mode != PM_WAIT) && (mode != PM_BACKUP) && (mode != PM_REGUP);
            corePowerEn        <= (mode != PM_BACKUP); // kept on in wait and sleep
            sramPowerEn        <= (mode != PM_BACKUP);
            regulatorOn        <= (mode != PM_BACKUP) && !bus.regDisable;
            regulatorOutputGnd <= (mode == PM_BACKUP);
            bus.coreRun        <= (mode == PM_RUN);
            bus.coreWake       <= (mode == PM_RESTORE) && (cnt == 16'(CLK_RESTORE_CYC - 1));
        end
    end

    assign bus.mode = mode;
endmodule

// *** lpmc_pkg.sv ***
// package: shared constants and types for the low-power mode control ends
package lpmc_pkg;
    // ****************************************************************
    // timing
    // ****************************************************************
    localparam int CLK_MHZ             = 25;
    localparam int WAIT_RESTART_NS     = 10000;  // restart from wait below this
    localparam int REG_STARTUP_NS      = 100000; // regulator start-up bound
    localparam int WAIT_RESTART_CYC    = WAIT_RESTART_NS * CLK_MHZ / 1000;
    localparam int REG_STARTUP_CYC     = (REG_STARTUP_NS * CLK_MHZ + 999) / 1000;
    localparam int SLOW_DIV            = 763;    // 25 MHz / 763 ~ 32.768 kHz tick
    localparam int CLK_RESTORE_CYC     = 2;      // clocks back before core runs
    localparam logic [15:0] WAKE_EN_RST   = 16'h0000;
    localparam logic [3:0]  DEBOUNCE_RST  = 4'hf; // saturated: a line arms only on a transition

    // ****************************************************************
    // power modes
    // ****************************************************************
    typedef enum logic [2:0] {
        PM_RUN     = 3'b000,
        PM_WAIT    = 3'b001,
        PM_SLEEP   = 3'b010,
        PM_BACKUP  = 3'b011,
        PM_REGUP   = 3'b100,
        PM_RESTORE = 3'b101
    } lpmc_mode_t;
endpackage

// *** lpmc_if.sv ***
// interface: core/software side joined to the power control side
`timescale 1ns/1ns
interface lpmc_if;
    logic        lowPowerSelect;        // mode select bit held by core side
    logic        waitForEventInstr;     // pulse: core executes wait-for-event
    logic        waitForInterruptInstr; // pulse: core executes wait-for-interrupt
    logic        backupReq;             // pulse: software enters backup
    logic        regDisable;            // level: regulator disabled by software
    logic        fastRcOscEnable;       // level: fast rc oscillator on
    logic        coreClkEn;             // core clock gate
    logic        coreRun;               // core may execute
    logic        coreWake;              // pulse: core resumes
    logic [2:0]  mode;                  // current power mode

    modport ctrl (input lowPowerSelect, waitForEventInstr, waitForInterruptInstr, backupReq, regDisable,
                  fastRcOscEnable, output coreClkEn, coreRun, coreWake, mode);
    modport core (output lowPowerSelect, waitForEventInstr, waitForInterruptInstr, backupReq, regDisable,
                  fastRcOscEnable, input coreClkEn, coreRun, coreWake, mode);
endinterface

// *** lpmc_core_end.sv ***
// core end: software sequencing of low-power entry
`timescale 1ns/1ns
module lpmc_core_end (
    input  wire logic clock,              // system clock
    input  wire logic sys_rst,            // synchronous reset, high
    lpmc_if.core      bus,                // link to power control
    input  wire logic userSelWait,        // 1 asks for wait, 0 for sleep
    input  wire logic userUseWfi,         // sleep entered by wait-for-interrupt
    input  wire logic userGo,             // pulse: start low-power entry
    input  wire logic userBackup,         // pulse: enter backup mode
    input  wire logic userRegDisable,     // regulator off request
    output logic      userBusy,           // entry sequence in progress
    output logic      userAwake           // core running
);
    import lpmc_pkg::*;

    typedef enum logic [2:0] {
        CS_IDLE = 3'b000, CS_RCSEL = 3'b001, CS_POLL = 3'b010, CS_SETSEL = 3'b011,
        CS_EXEC = 3'b100, CS_LOW = 3'b101
    } lpmc_cstate_t;
    lpmc_cstate_t state;
    logic         useWfi;

    // ****************************************************************
    // entry sequence: fast rc and poll for wait only, then select bit, instruction
    // ****************************************************************
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            state                     <= CS_IDLE;
            useWfi                    <= 1'b0;
            bus.lowPowerSelect        <= 1'b0;
            bus.fastRcOscEnable       <= 1'b1;
            bus.waitForEventInstr     <= 1'b0;
            bus.waitForInterruptInstr <= 1'b0;
        end else begin
            bus.waitForEventInstr     <= 1'b0;
            bus.waitForInterruptInstr <= 1'b0;
            case (state)
                CS_IDLE: begin
                    if (userGo) begin
                        useWfi <= userUseWfi & ~userSelWait;
                        state  <= userSelWait ? CS_RCSEL : CS_SETSEL;
                    end
                end
                CS_RCSEL: begin
                    bus.fastRcOscEnable <= 1'b0; // main clock hands over
                    state <= CS_POLL;
                end
                CS_POLL: begin
                    if (!bus.fastRcOscEnable) begin
                        state <= CS_SETSEL; // enable reads cleared, set select next
                    end
                end
                CS_SETSEL: begin
                    bus.lowPowerSelect <= (useWfi ? 1'b0 : userSelWait);
                    state <= CS_EXEC;
                end
                CS_EXEC: begin
                    if (useWfi) begin
                        bus.waitForInterruptInstr <= 1'b1;
                    end else begin
                        bus.waitForEventInstr <= 1'b1;
                    end
                    state <= CS_LOW;
                end
                CS_LOW: begin
                    if (bus.coreWake) begin
                        bus.fastRcOscEnable <= 1'b1;
                        state <= CS_IDLE;
                    end
                end
                default: state <= CS_IDLE;
            endcase
        end
    end

    // ****************************************************************
    // backup requests pass only in idle; regulator request passes straight through
    // ****************************************************************
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            bus.backupReq  <= 1'b0;
            bus.regDisable <= 1'b0;
        end else begin
            bus.backupReq  <= userBackup & (state == CS_IDLE);
            bus.regDisable <= userRegDisable;
        end
    end

    assign userBusy  = (state != CS_IDLE);
    assign userAwake = bus.coreRun;
endmodule

// *** lpmc_checker.sv ***
// checker: timing relations on the link between the two power control ends
`timescale 1ns/1ns
module lpmc_checker (
    input wire logic       clock,                 // system clock
    input wire logic       sys_rst,               // sync reset, high
    input wire logic       lowPowerSelect,        // wait/sleep select
    input wire logic       waitForEventInstr,     // wfe pulse
    input wire logic       waitForInterruptInstr, // wfi pulse
    input wire logic       backupReq,             // backup pulse
    input wire logic       fastRcOscEnable,       // fast rc on
    input wire logic       coreClkEn,             // core clock gate
    input wire logic       coreRun,               // core executes
    input wire logic       coreWake,              // resume pulse
    input wire logic [2:0] mode                   // power mode
);
    import lpmc_pkg::*;
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);
    // ****************************************************************
    // regulator wait counter
    // ****************************************************************
    logic [11:0] regupCnt; // saturating is not needed: the wait is bounded well below 4096
    // counts sampled cycles spent in regulator start-up
    always_ff @(posedge clock) begin
        if (sys_rst || mode != PM_REGUP)
            regupCnt <= 12'h000;
        else
            regupCnt <= regupCnt + 12'h001;
    end
    // ****************************************************************
    // assertions
    // ****************************************************************
    wait_entry_a:
        assert property (mode == PM_RUN && waitForEventInstr && lowPowerSelect && !backupReq |=> mode == PM_WAIT)
        else $error("wait entry missed");
    sleep_entry_a:
        assert property (mode == PM_RUN && !backupReq && (waitForInterruptInstr || waitForEventInstr && !lowPowerSelect)
            |=> mode == PM_SLEEP) else $error("sleep entry missed");
    wait_gates_a:
        assert property (mode == PM_WAIT && $past(mode) == PM_WAIT |-> !coreClkEn && !coreRun)
        else $error("core clock running in wait");
    sleep_gates_a:
        assert property (mode == PM_SLEEP && $past(mode) == PM_SLEEP |-> !coreClkEn && !coreRun)
        else $error("core clock running in sleep");
    fast_rc_first_a:
        assert property (waitForEventInstr && lowPowerSelect |-> !fastRcOscEnable)
        else $error("wait issued with fast rc still on");
    select_hold_a:
        assert property (mode != PM_RUN && $past(mode) != PM_RUN |-> $stable(lowPowerSelect))
        else $error("select bit moved while asleep");
    wake_order_a:
        assert property (coreWake |-> coreClkEn && $past(coreClkEn) && mode == PM_RUN)
        else $error("core resumed before its clock");
    wake_pulse_a:
        assert property (coreWake |=> coreRun && !coreWake)
        else $error("wake pulse malformed");
    restart_bound_a:
        assert property ($past(mode) == PM_WAIT && mode == PM_RESTORE |-> ##[1:4] mode == PM_RUN)
        else $error("restart from wait too slow");
    regup_hold_a:
        assert property (mode == PM_REGUP |-> !coreRun && !coreWake)
        else $error("core released during regulator start-up");
    regup_len_a:
        assert property (mode == PM_RESTORE && $past(mode) == PM_REGUP |-> regupCnt >= REG_STARTUP_CYC)
        else $error("regulator start-up wait too short");
    cover property (mode == PM_RUN ##1 mode == PM_WAIT);
    cover property (mode == PM_RUN ##1 mode == PM_SLEEP);
    cover property (mode == PM_REGUP ##1 mode == PM_RESTORE);
    cover property (coreWake);
endmodule

// *** tb_low_power_mode_control.sv ***
// testbench: both power control ends joined, user and wake sides driven
`timescale 1ns/1ns
module tb_low_power_mode_control;
    import lpmc_pkg::*;
    typedef struct {logic sel; logic wait_for_interrupt_instr; int src; logic [2:0] m;} lpmc_row_t;
    logic clock = 1'h0, sys_rst = 1'h1, userSelWait = 1'h0, userUseWfi = 1'h0, userGo = 1'h0;
    logic userBackup = 1'h0, userRegDisable = 1'h0, calendarAlarm = 1'h0, realtimeTimerAlarm = 1'h0;
    logic usbWake = 1'h0, supplyMonAlarm = 1'h0, irqPending = 1'h0, eventPending = 1'h0;
    logic [15:0] fastWakeLines = 16'h0000, fastWakeEnable = 16'hfffe, backupWakeInputs = 16'h0000;
    logic [15:0] backupWakeEnable = 16'h0008;
    logic [3:0]  debounceTicks = 4'h1;
    logic userBusy, userAwake, periphClkEn, memClkEn, corePowerEn, sramPowerEn, regulatorOn, regulatorOutputGnd;
    int err_total = 0, total_checks = 0, n;
    int bsrc [4] = '{21, 16, 17, 22};
    // ordinary cases: wake line, alarms and sleep exits
    lpmc_row_t rows [7] = '{'{1'h1, 1'h0, 1, PM_WAIT}, '{1'h1, 1'h0, 15, PM_WAIT}, '{1'h1, 1'h0, 16, PM_WAIT},
        '{1'h1, 1'h0, 17, PM_WAIT}, '{1'h1, 1'h0, 18, PM_WAIT}, '{1'h0, 1'h1, 19, PM_SLEEP},
        '{1'h0, 1'h0, 20, PM_SLEEP}};
    lpmc_if lnk ();
    lpmc_core_end lpmc_core_end_i (.clock, .sys_rst, .bus(lnk), .userSelWait, .userUseWfi, .userGo,
        .userBackup, .userRegDisable, .userBusy, .userAwake);
    lpmc_ctrl_end lpmc_ctrl_end_i (.clock, .sys_rst, .bus(lnk), .fastWakeLines, .fastWakeEnable,
        .backupWakeInputs, .backupWakeEnable, .debounceTicks, .calendarAlarm, .realtimeTimerAlarm, .usbWake,
        .supplyMonAlarm, .irqPending, .eventPending, .periphClkEn, .memClkEn, .corePowerEn, .sramPowerEn,
        .regulatorOn, .regulatorOutputGnd);
    lpmc_checker lpmc_checker_i (.clock(clock), .sys_rst(sys_rst), .lowPowerSelect(lnk.lowPowerSelect),
        .waitForEventInstr(lnk.waitForEventInstr), .waitForInterruptInstr(lnk.waitForInterruptInstr),
        .backupReq(lnk.backupReq), .fastRcOscEnable(lnk.fastRcOscEnable), .coreClkEn(lnk.coreClkEn),
        .coreRun(lnk.coreRun), .coreWake(lnk.coreWake), .mode(lnk.mode));
    // free-running 25 MHz clock
    always #20 clock = ~clock;
    // ****************************************************************
    // helpers
    // ****************************************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    // wake sources by number: fast lines 0-15, then alarms, usb, irq, event, supply monitor, backup line 3
    task automatic set_src(input int s, input logic v);
        if (s < 16) fastWakeLines[s] = v;
        else case (s)
            16: calendarAlarm = v;
            17: realtimeTimerAlarm = v;
            18: usbWake = v;
            19: irqPending = v;
            20: eventPending = v;
            21: supplyMonAlarm = v;
            default: backupWakeInputs[3] = v;
        endcase
    endtask
    // bounded wait so a stuck mode shows as a mismatch, not a hang
    task automatic wait_mode(input logic [2:0] m, input int lim, output int cnt);
        cnt = 0;
        while (lnk.mode !== m && cnt < lim) begin
            @(negedge clock);
            cnt++;
        end
        check(lnk.mode, m);
    endtask
    task automatic enter(input logic sel, input logic wait_for_interrupt_instr, input logic [2:0] m);
        int c;
        // the core end ignores a start until it has taken its last wake
        while (userBusy) @(negedge clock);
        userSelWait = sel;
        userUseWfi = wait_for_interrupt_instr;
        userGo = 1'h1;
        @(negedge clock);
        userGo = 1'h0;
        wait_mode(m, 40, c);
        repeat (2) @(negedge clock);
    endtask
    task automatic give_verdict();
        $display("checks %0d, mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // ****************************************************************
    // sequence
    // ****************************************************************
    initial begin
        repeat (40000) @(posedge clock);
        err_total++;
        give_verdict();
    end
    initial begin
        repeat (20) @(negedge clock);
        sys_rst = 1'h0;
        repeat (3) @(negedge clock);
        check({lnk.mode, lnk.coreClkEn, periphClkEn, memClkEn, corePowerEn, regulatorOutputGnd}, 8'h1e);
        check({lnk.lowPowerSelect, lnk.fastRcOscEnable, lnk.coreRun}, 3'h3);
        foreach (rows[i]) begin
            enter(rows[i].sel, rows[i].wait_for_interrupt_instr, rows[i].m);
            check(lnk.coreClkEn, 1'h0);
            check({periphClkEn, memClkEn}, {2{!rows[i].sel}});
            check({corePowerEn, sramPowerEn, regulatorOn}, 3'h7);
            check(lnk.lowPowerSelect, rows[i].sel);
            check({userBusy, userAwake}, 2'h2);
            set_src(rows[i].src, 1'h1);
            wait_mode(PM_RUN, 300, n);
            @(negedge clock);
            check({lnk.coreRun, lnk.lowPowerSelect}, {1'h1, rows[i].sel});
            check({userAwake, userBusy}, 2'h2);
            check(n + 1 < WAIT_RESTART_CYC, 1'h1);
            set_src(rows[i].src, 1'h0);
            repeat (4) @(negedge clock);
        end
        // a disabled fast line must not end wait
        enter(1'h1, 1'h0, PM_WAIT);
        set_src(0, 1'h1);
        repeat (20) @(negedge clock);
        check(lnk.mode, PM_WAIT);
        set_src(0, 1'h0);
        set_src(18, 1'h1);
        wait_mode(PM_RUN, 300, n);
        set_src(18, 1'h0);
        // sleep entered by wfi ignores a bare event
        enter(1'h0, 1'h1, PM_SLEEP);
        eventPending = 1'h1;
        repeat (20) @(negedge clock);
        check(lnk.mode, PM_SLEEP);
        eventPending = 1'h0;
        irqPending = 1'h1;
        wait_mode(PM_RUN, 300, n);
        irqPending = 1'h0;
        userRegDisable = 1'h1;
        repeat (4) @(negedge clock);
        check({regulatorOn, regulatorOutputGnd, lnk.mode}, {2'h0, PM_RUN});
        userRegDisable = 1'h0;
        repeat (4) @(negedge clock);
        // backup, woken by supply monitor, both alarms, then a debounced line
        foreach (bsrc[k]) begin
            userBackup = 1'h1;
            @(negedge clock);
            userBackup = 1'h0;
            wait_mode(PM_BACKUP, 40, n);
            repeat (2) @(negedge clock);
            check({corePowerEn, sramPowerEn, regulatorOn, regulatorOutputGnd}, 4'h1);
            set_src(bsrc[k], 1'h1);
            wait_mode(PM_REGUP, 3000, n);
            wait_mode(PM_RESTORE, 3000, n);
            check(n >= REG_STARTUP_CYC - 1, 1'h1);
            wait_mode(PM_RUN, 10, n);
            @(negedge clock);
            check({corePowerEn, sramPowerEn, regulatorOn, regulatorOutputGnd, lnk.coreRun}, 5'h1d);
            set_src(bsrc[k], 1'h0);
        end
        // reset in mid-wait puts every gate, supply and link bit back to its run value
        enter(1'h1, 1'h0, PM_WAIT);
        sys_rst = 1'h1;
        repeat (3) @(negedge clock);
        sys_rst = 1'h0;
        repeat (2) @(negedge clock);
        check({lnk.mode, lnk.coreClkEn, periphClkEn, memClkEn, corePowerEn, regulatorOutputGnd}, 8'h1e);
        check({lnk.lowPowerSelect, lnk.fastRcOscEnable, lnk.coreRun, userBusy}, 4'h6);
        give_verdict();
    end
endmodule
